// file: etd_dma_dev.sv
// transmit descriptor dma end: walks the descriptor list, streams buffer data
// to the transmit block and writes status back to each frame's first descriptor
// assumes one clock for software, bus and transmit block; the bus holds no order
// Notes on behaviour
// [R1] buffers of 0 to 2047 bytes, zero skipped
// [R2] software keeps frames at 128 buffers or fewer
// [R3] two-word descriptors, list starts at queue pointer
// [R4] crc frames are padded to 64 bytes
// [R5] last bit and length field size the frame
// [R6] no-crc bit on last buffer suppresses crc
// [R7] transmit only unused buffers, then mark used
// [R8] status written to first descriptor only
// [R9] retry, underrun, exhausted reported as separate bits
// [R10] wrap bit or 1024 descriptors return to start
// [R11] software leaves queue pointer alone while active
// [R12] queue pointer write restarts at new queue
// [R13] transmit disable returns pointer to queue start
// [R14] start sets go, repeat start is harmless
// [R15] go state readable in status register
// [R16] go clears on disable, used, pointer, halt, error
// [R17] halt waits for the current frame to finish
// [R18] collision restarts frame from its first descriptor
// [R19] used bit mid-frame is a transmit error
// [R20] after error pointer returns to queue start
// [R21] used bit at frame start keeps the pointer
// [R22] pause with pause enabled holds new frames
// [R23] otherwise next descriptor follows in memory
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "etd_regs.svh"
module etd_dma_dev #(
  parameter int DESC_COUNT = `ETD_DESC_COUNT
) (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [7:0]    sw_addr_in,
  input  wire logic [31:0]   sw_wdata_in,
  input  wire logic          sw_wr_in,
  input  wire logic          sw_rd_in,
  output etd_pkg::etd_word_t sw_rdata_out,
  etd_bus_if.dev             bus_io,
  output etd_pkg::etd_word_t tx_data_out,
  output logic [2:0]         tx_bytes_out,
  output logic               tx_valid_out,
  input  wire logic          tx_ready_in,
  output logic               tx_last_out,
  output logic               tx_nocrc_out,
  output logic               tx_bad_fcs_out,
  output logic               transmit_fault_output_out,
  input  wire logic          tx_done_in,
  input  wire logic          tx_collision_in,
  input  wire logic          tx_retry_fail_in,
  input  wire logic          tx_late_in,
  input  wire logic          pause_in
);
  import etd_pkg::*;
  localparam int IDX_W = $clog2(DESC_COUNT);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DESC_COUNT - 1);
  if (DESC_COUNT < 2 || DESC_COUNT > `ETD_DESC_COUNT || (1 << IDX_W) != DESC_COUNT) begin : g_chk
    $error("DESC_COUNT must be a power of two from 2 to 1024");
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [2:0] beat_bytes(input logic [1:0] off, input logic [10:0] rem);
    logic [2:0] avail;
    avail = `ETD_BEAT_BYTES - {1'b0, off};
    return (rem < {8'h00, avail}) ? rem[2:0] : avail;
  endfunction
  function automatic logic [6:0] sat_add(input logic [6:0] cnt, input logic [2:0] b);
    logic [7:0] sum;
    sum = {1'b0, cnt} + {5'h00, b};
    return (sum > {1'b0, `ETD_MIN_FRAME}) ? `ETD_MIN_FRAME : sum[6:0];
  endfunction
  function automatic etd_word_t desc_w1(input etd_word_t base, input logic [IDX_W-1:0] idx);
    return base + 32'({idx, 3'h0}) + `ETD_W1_OFS;
  endfunction
  etd_state_t       state_ff;
  etd_word_t        base_ff, ctrl_ff, first_ctrl_ff, buf_addr_ff, err_bits_ff, rdata_ff;
  logic [IDX_W-1:0] idx_ff, first_idx_ff;
  logic [10:0]      rem_ff;
  logic [6:0]       fbytes_ff;
  logic             txen_ff, pause_en_ff, go_ff, halt_pend_ff, first_ff;
  logic             col_pend_ff, late_pend_ff, kill_pend_ff, req_ff, we_ff;
  etd_word_t        addr_ff, wdata_ff, ptr;
  logic             wr_ctrl, start_wr, halt_wr, dis_wr, qptr_wr, in_frame;
  logic [6:0]       pad_left;
  assign ptr      = base_ff + 32'({idx_ff, 3'h0});
  assign wr_ctrl  = sw_wr_in && (sw_addr_in == `ETD_A_CTRL);
  assign start_wr = wr_ctrl && sw_wdata_in[`ETD_CTRL_START] && sw_wdata_in[`ETD_CTRL_TXEN];
  assign halt_wr  = wr_ctrl && sw_wdata_in[`ETD_CTRL_HALT];
  assign dis_wr   = wr_ctrl && !sw_wdata_in[`ETD_CTRL_TXEN];
  assign qptr_wr  = sw_wr_in && (sw_addr_in == `ETD_A_QPTR);
  assign in_frame = !(state_ff inside {ST_IDLE, ST_WB, ST_ERR_END, ST_CTRL}) || !first_ff;
  assign pad_left = `ETD_MIN_FRAME - `ETD_CRC_BYTES - fbytes_ff;
  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      base_ff     <= 32'h0000_0000;
      txen_ff     <= 1'b0;
      pause_en_ff <= 1'b0;
    end else begin
      if (wr_ctrl) txen_ff <= sw_wdata_in[`ETD_CTRL_TXEN];
      if (sw_wr_in && sw_addr_in == `ETD_A_CFG) pause_en_ff <= sw_wdata_in[`ETD_CFG_PAUSE];
      if (qptr_wr) base_ff <= sw_wdata_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (sw_rd_in) begin
        case (sw_addr_in)
          `ETD_A_CTRL: rdata_ff[`ETD_CTRL_TXEN] <= txen_ff;
          `ETD_A_CFG:  rdata_ff[`ETD_CFG_PAUSE] <= pause_en_ff;
          `ETD_A_QPTR: rdata_ff <= ptr;
          `ETD_A_STAT: begin
            rdata_ff[`ETD_STAT_GO]   <= go_ff; // see [R15]
            rdata_ff[`ETD_STAT_BUSY] <= (state_ff != ST_IDLE);
          end
          default:     rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ------------------------------------------------------------------
  // descriptor walk and frame streaming
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;       ctrl_ff <= 32'h0000_0000;  first_ctrl_ff <= 32'h0000_0000;
      buf_addr_ff <= 32'h0000_0000; err_bits_ff <= 32'h0000_0000;
      idx_ff <= '0;              first_idx_ff <= '0;        rem_ff <= 11'h000;
      fbytes_ff <= 7'h00;        go_ff <= 1'b0;             halt_pend_ff <= 1'b0;
      first_ff <= 1'b1;          col_pend_ff <= 1'b0;       late_pend_ff <= 1'b0;
      kill_pend_ff <= 1'b0;      req_ff <= 1'b0;            we_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;  wdata_ff <= 32'h0000_0000;
      tx_data_out <= 32'h0000_0000; tx_bytes_out <= 3'h0;   tx_valid_out <= 1'b0;
      tx_last_out <= 1'b0;       tx_nocrc_out <= 1'b0;      tx_bad_fcs_out <= 1'b0;
      transmit_fault_output_out <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: if (go_ff && !halt_pend_ff && !(pause_en_ff && pause_in)) begin // see [R22]
          first_ff <= 1'b1;  first_idx_ff <= idx_ff;  fbytes_ff <= 7'h00;
          err_bits_ff <= 32'h0000_0000;
          req_ff <= 1'b1;  we_ff <= 1'b0;  addr_ff <= desc_w1(base_ff, idx_ff); // see [R3]
          state_ff <= ST_CTRL;
        end
        ST_CTRL: if (bus_io.ack) begin
          req_ff <= 1'b0;
          if (bus_io.err) begin
            err_bits_ff[`ETD_D_UNDR] <= 1'b1; // see [R9]
            state_ff <= ST_ERR_END;
          end else if (bus_io.rdata[`ETD_D_USED]) begin // see [R7]
            if (first_ff) begin
              go_ff <= 1'b0; // see [R16] [R21]
              halt_pend_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              err_bits_ff[`ETD_D_UNDR] <= 1'b1; // see [R19] [R9]
              err_bits_ff[`ETD_D_EXH] <= 1'b1;
              state_ff <= ST_ERR_END;
            end
          end else begin
            ctrl_ff <= bus_io.rdata;
            if (first_ff) first_ctrl_ff <= bus_io.rdata;
            req_ff <= 1'b1;  addr_ff <= ptr;
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: if (bus_io.ack) begin
          req_ff <= 1'b0;  first_ff <= 1'b0;
          if (ctrl_ff[`ETD_D_WRAP] || idx_ff == LAST_IDX) idx_ff <= '0; // see [R10]
          else idx_ff <= idx_ff + 1'b1; // see [R23]
          if (bus_io.err) begin
            err_bits_ff[`ETD_D_UNDR] <= 1'b1;
            state_ff <= ST_ERR_END;
          end else begin
            buf_addr_ff <= bus_io.rdata;
            rem_ff <= ctrl_ff[`ETD_D_LEN_MSB:0]; // see [R5]
            if (ctrl_ff[`ETD_D_LEN_MSB:0] == 11'h000) state_ff <= ST_NEXT; // see [R1]
            else begin
              req_ff <= 1'b1;  addr_ff <= {bus_io.rdata[31:2], 2'h0};
              state_ff <= ST_FETCH;
            end
          end
        end
        ST_NEXT: if (ctrl_ff[`ETD_D_LAST]) begin // see [R5]
          // padding only where the transmit block will add crc
          if (ctrl_ff[`ETD_D_NOCRC] || pad_left == 7'h00 || pad_left[6]) state_ff <= ST_END; // see [R6]
          else state_ff <= ST_PAD; // see [R4]
        end else begin
          req_ff <= 1'b1;  addr_ff <= desc_w1(base_ff, idx_ff);
          state_ff <= ST_CTRL;
        end
        ST_FETCH: if (bus_io.ack) begin
          req_ff <= 1'b0;
          if (bus_io.err) begin
            err_bits_ff[`ETD_D_UNDR] <= 1'b1; // see [R9]
            state_ff <= ST_ERR_END;
          end else begin
            tx_data_out  <= bus_io.rdata >> {buf_addr_ff[1:0], 3'h0};
            tx_bytes_out <= beat_bytes(buf_addr_ff[1:0], rem_ff);
            tx_valid_out <= 1'b1;
            buf_addr_ff  <= buf_addr_ff + 32'(beat_bytes(buf_addr_ff[1:0], rem_ff));
            rem_ff       <= rem_ff - 11'(beat_bytes(buf_addr_ff[1:0], rem_ff));
            fbytes_ff    <= sat_add(fbytes_ff, beat_bytes(buf_addr_ff[1:0], rem_ff));
            state_ff     <= ST_SEND;
          end
        end
        ST_SEND: if (tx_ready_in) begin
          tx_valid_out <= 1'b0;
          if (rem_ff == 11'h000) state_ff <= ST_NEXT;
          else begin
            req_ff <= 1'b1;  addr_ff <= {buf_addr_ff[31:2], 2'h0};
            state_ff <= ST_FETCH;
          end
        end
        ST_PAD: if (!tx_valid_out) begin
          tx_data_out  <= 32'h0000_0000;
          tx_bytes_out <= (pad_left > 7'(`ETD_BEAT_BYTES)) ? `ETD_BEAT_BYTES : pad_left[2:0]; // see [R4]
          tx_valid_out <= 1'b1;
        end else if (tx_ready_in) begin
          tx_valid_out <= 1'b0;
          fbytes_ff <= sat_add(fbytes_ff, tx_bytes_out);
          if (pad_left <= 7'(tx_bytes_out)) state_ff <= ST_END;
        end
        ST_END, ST_ERR_END: if (!tx_valid_out) begin
          tx_data_out  <= 32'h0000_0000;
          tx_bytes_out <= 3'h0;
          tx_valid_out <= 1'b1;
          tx_last_out  <= 1'b1;
          tx_nocrc_out <= ctrl_ff[`ETD_D_NOCRC] && (state_ff == ST_END); // see [R6]
          tx_bad_fcs_out <= (state_ff == ST_ERR_END); // see [R19]
          transmit_fault_output_out <= (state_ff == ST_ERR_END);
        end else if (tx_ready_in) begin
          tx_valid_out <= 1'b0;  tx_last_out <= 1'b0;
          tx_nocrc_out <= 1'b0;  tx_bad_fcs_out <= 1'b0;
          transmit_fault_output_out <= 1'b0;
          if (state_ff == ST_END) state_ff <= ST_WAIT;
          else begin
            req_ff <= 1'b1;  we_ff <= 1'b1;  addr_ff <= desc_w1(base_ff, first_idx_ff);
            wdata_ff <= first_ctrl_ff | err_bits_ff | (32'h1 << `ETD_D_USED);
            state_ff <= ST_WB;
          end
        end
        ST_WAIT: if (tx_done_in || tx_retry_fail_in) begin
          req_ff <= 1'b1;  we_ff <= 1'b1;  addr_ff <= desc_w1(base_ff, first_idx_ff); // see [R8]
          wdata_ff <= first_ctrl_ff | (32'(tx_retry_fail_in) << `ETD_D_RETRY) // see [R9]
                      | (32'h1 << `ETD_D_USED); // see [R7]
          err_bits_ff[`ETD_D_RETRY] <= tx_retry_fail_in;
          state_ff <= ST_WB;
        end
        ST_WB: if (bus_io.ack) begin
          req_ff <= 1'b0;  we_ff <= 1'b0;
          if (err_bits_ff != 32'h0000_0000 || bus_io.err) begin
            go_ff <= 1'b0; // see [R16]
            idx_ff <= '0; // see [R20]
            halt_pend_ff <= 1'b0;
          end else if (halt_pend_ff) begin
            go_ff <= 1'b0; // see [R17]
            halt_pend_ff <= 1'b0;
          end
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
      // frame aborts wait until no bus request is open
      if (!req_ff && late_pend_ff && state_ff inside {ST_NEXT, ST_SEND, ST_PAD, ST_END}) begin
        late_pend_ff <= 1'b0;  tx_valid_out <= 1'b0;  tx_last_out <= 1'b0;
        err_bits_ff[`ETD_D_UNDR] <= 1'b1; // see [R9]
        state_ff <= ST_ERR_END;
      end else if (!req_ff && col_pend_ff && state_ff inside {ST_NEXT, ST_SEND, ST_PAD, ST_END, ST_WAIT}) begin
        col_pend_ff <= 1'b0;  tx_valid_out <= 1'b0;  tx_last_out <= 1'b0;
        tx_nocrc_out <= 1'b0;
        first_ff <= 1'b1;  fbytes_ff <= 7'h00;  idx_ff <= first_idx_ff; // see [R18]
        req_ff <= 1'b1;  we_ff <= 1'b0;  addr_ff <= desc_w1(base_ff, first_idx_ff);
        state_ff <= ST_CTRL;
      end
      if (state_ff inside {ST_IDLE, ST_WB, ST_ERR_END}) begin
        col_pend_ff <= 1'b0;
        late_pend_ff <= 1'b0;
      end
      if (tx_collision_in && in_frame && state_ff != ST_ERR_END) col_pend_ff <= 1'b1;
      if (tx_late_in && in_frame && state_ff != ST_WAIT) late_pend_ff <= 1'b1;
      if (kill_pend_ff && !req_ff) begin
        kill_pend_ff <= 1'b0;  tx_valid_out <= 1'b0;  tx_last_out <= 1'b0;
        tx_nocrc_out <= 1'b0;  tx_bad_fcs_out <= 1'b0;
        transmit_fault_output_out <= 1'b0;  we_ff <= 1'b0;
        idx_ff <= '0;
        state_ff <= ST_IDLE;
      end
      // software commands override the walk
      if (start_wr) go_ff <= 1'b1; // see [R14]
      if (halt_wr) begin
        if (state_ff == ST_IDLE) go_ff <= 1'b0; // see [R16]
        else halt_pend_ff <= 1'b1; // see [R17]
      end
      if (qptr_wr) begin
        go_ff <= 1'b0; // see [R16]
        idx_ff <= '0; // see [R12]
      end
      if (dis_wr) begin
        go_ff <= 1'b0;
        halt_pend_ff <= 1'b0;
        idx_ff <= '0; // see [R13]
        if (state_ff != ST_IDLE) kill_pend_ff <= 1'b1;
      end
    end
  end
  assign sw_rdata_out = rdata_ff;
  assign bus_io.req   = req_ff;
  assign bus_io.we    = we_ff;
  assign bus_io.addr  = addr_ff;
  assign bus_io.wdata = wdata_ff;
endmodule // etd_dma_dev
`default_nettype wire

// file: etd_regs.svh
// register offsets, field positions and fixed counts of the transmit descriptor dma
// assumes inclusion by bare name from every design file of the block
`ifndef ETD_REGS_SVH
`define ETD_REGS_SVH
// ------------------------------------------------------------------
// software register offsets
// ------------------------------------------------------------------
`define ETD_A_CTRL      8'h00
`define ETD_A_CFG       8'h04
`define ETD_A_QPTR      8'h08
`define ETD_A_STAT      8'h0C
// ------------------------------------------------------------------
// register bit positions
// ------------------------------------------------------------------
`define ETD_CTRL_TXEN   3
`define ETD_CTRL_START  9
`define ETD_CTRL_HALT   10
`define ETD_CFG_PAUSE   13
`define ETD_STAT_GO     3
`define ETD_STAT_BUSY   4
// ------------------------------------------------------------------
// descriptor layout
// ------------------------------------------------------------------
`define ETD_D_USED      31
`define ETD_D_WRAP      30
`define ETD_D_RETRY     29
`define ETD_D_UNDR      28
`define ETD_D_EXH       27
`define ETD_D_NOCRC     16
`define ETD_D_LAST      15
`define ETD_D_LEN_MSB   10
`define ETD_W1_OFS      32'h0000_0004
`define ETD_DESC_COUNT  1024
`define ETD_MAX_BUFS    128
// ------------------------------------------------------------------
// frame sizes in bytes
// ------------------------------------------------------------------
`define ETD_MIN_FRAME   7'h40
`define ETD_CRC_BYTES   7'h04
`define ETD_BEAT_BYTES  3'h4
`endif

// file: etd_pkg.sv
// types shared by both ends of the transmit descriptor dma
// assumes nothing beyond a systemverilog compiler
package etd_pkg;
  typedef logic [31:0] etd_word_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CTRL, ST_ADDR, ST_NEXT, ST_FETCH, ST_SEND,
    ST_PAD, ST_END, ST_WAIT, ST_ERR_END, ST_WB
  } etd_state_t;
  typedef enum logic [1:0] {PS_IDLE, PS_BUSY, PS_DONE} etd_port_state_t;
endpackage

// file: etd_bus_if.sv
// word bus between the dma end and the memory port end
// assumes both ends run on the same clock; a request is held until ack
`timescale 1ns/1ns
`default_nettype none
interface etd_bus_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        err;
  modport dev (output req, we, addr, wdata, input ack, rdata, err);
  modport mem (input req, we, addr, wdata, output ack, rdata, err);
endinterface
`default_nettype wire

// file: etd_mem_port.sv
// memory port end: takes dma word requests and runs them on a plain memory port
// assumes a memory on the same clock that answers each request with one ack pulse
`timescale 1ns/1ns
`default_nettype none
`include "etd_regs.svh"
module etd_mem_port (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  etd_bus_if.mem             bus_io,
  output logic               mem_req_out,
  output logic               mem_we_out,
  output etd_pkg::etd_word_t mem_addr_out,
  output etd_pkg::etd_word_t mem_wdata_out,
  input  wire logic [31:0]   mem_rdata_in,
  input  wire logic          mem_ack_in,
  input  wire logic          mem_err_in
);
  import etd_pkg::*;
  etd_port_state_t st_ff;
  logic            ack_ff;
  logic            err_ff;
  etd_word_t       rdata_ff;
  // ------------------------------------------------------------------
  // request handling
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_ff         <= PS_IDLE;
      ack_ff        <= 1'b0;
      err_ff        <= 1'b0;
      rdata_ff      <= 32'h0000_0000;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 32'h0000_0000;
      mem_wdata_out <= 32'h0000_0000;
    end else begin
      case (st_ff)
        PS_IDLE: if (bus_io.req) begin
          // descriptor words are whole aligned words
          if (bus_io.addr[1:0] != 2'h0) begin // see [R3]
            err_ff   <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            ack_ff   <= 1'b1;
            st_ff    <= PS_DONE;
          end else begin
            mem_req_out   <= 1'b1;
            mem_we_out    <= bus_io.we;
            mem_addr_out  <= bus_io.addr;
            mem_wdata_out <= bus_io.wdata;
            st_ff         <= PS_BUSY;
          end
        end
        PS_BUSY: if (mem_ack_in) begin
          mem_req_out <= 1'b0;
          rdata_ff    <= mem_rdata_in;
          err_ff      <= mem_err_in;
          ack_ff      <= 1'b1;
          st_ff       <= PS_DONE;
        end
        PS_DONE: begin
          // the dma still shows req in this cycle; it must not be taken again
          ack_ff <= 1'b0;
          err_ff <= 1'b0;
          st_ff  <= PS_IDLE;
        end
        default: st_ff <= PS_IDLE;
      endcase
    end
  end
  assign bus_io.ack   = ack_ff;
  assign bus_io.err   = err_ff;
  assign bus_io.rdata = rdata_ff;
endmodule // etd_mem_port
`default_nettype wire

// file: etd_bus_chk.sv
// checker of the word bus between the two ends
// assumes 8-byte aligned descriptor lists; placed beside the interface
`timescale 1ns/1ns
`default_nettype none
`include "etd_regs.svh"
module etd_bus_chk (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        req,
  input wire logic        we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // handshake and status writeback
  // ----------------------------------------
  property p_hold; req && !ack |=> req && $stable({we, addr, wdata}); endproperty
  a_hold: assert property (p_hold) else $error("request moved before ack");
  property p_align; req |-> addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("address not word aligned");
  property p_ack_one; ack |=> !ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_bound; $rose(req) |-> ##[1:24] ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("request not answered");
  property p_wb_word1; req && we |-> addr[2:0] == 3'h4; endproperty
  a_wb_word1: assert property (p_wb_word1) else $error("write not to control word");
  property p_wb_used; req && we |-> wdata[`ETD_D_USED]; endproperty
  a_wb_used: assert property (p_wb_used) else $error("writeback without used bit");
  property p_wb_rsvd; req && we |-> wdata[26:17] == 10'h000 && wdata[14:11] == 4'h0; endproperty
  a_wb_rsvd: assert property (p_wb_rsvd) else $error("writeback reserved bits set");
endmodule // etd_bus_chk
`default_nettype wire

// file: eth_tx_descriptor_dma_tb.sv
// bench: both ends on the word bus; memory and sink modelled here
// assumes descriptor lists on 8-byte boundaries inside a 1 KB memory
`timescale 1ns/1ns
`default_nettype none
`include "etd_regs.svh"
module eth_tx_descriptor_dma_tb;
  import etd_pkg::*;
  localparam logic [7:0] ct = `ETD_A_CTRL, cf = `ETD_A_CFG, qp = `ETD_A_QPTR, st = `ETD_A_STAT;
  logic       clk = 0, rst_n = 0, sw_wr = 0, sw_rd = 0, pause = 0, rfail = 0, colf = 1;
  logic       mem_ack = 0, tx_ready = 0, tx_done = 0, tx_rfail = 0, tx_col = 0;
  logic       mem_req, mem_we, tx_valid, tx_last, tx_nocrc, tx_bad, tx_fault;
  logic [2:0] tx_bytes, flags = 0;
  logic [7:0] sw_addr = 0, got[$], want[$];
  etd_word_t  sw_wdata = 0, mem_rdata = 0, sw_rdata, tx_data, mem_addr, mem_wdata, mem[256];
  int         ends = 0, dly = 0, cyc = 0, error_cnt = 0, comparisons = 0;
  // ----------------------------------------
  // both ends, bus and checker
  // ----------------------------------------
  etd_bus_if bus ();
  etd_dma_dev #(.DESC_COUNT(4)) i_etd_dma_dev (.ref_clk_in(clk), .rst_n_in(rst_n),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .sw_rdata_out(sw_rdata), .bus_io(bus), .tx_data_out(tx_data), .tx_bytes_out(tx_bytes),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_last_out(tx_last),
    .tx_nocrc_out(tx_nocrc), .tx_bad_fcs_out(tx_bad), .transmit_fault_output_out(tx_fault),
    .tx_done_in(tx_done), .tx_collision_in(tx_col), .tx_retry_fail_in(tx_rfail),
    .tx_late_in(1'b0), .pause_in(pause));
  etd_mem_port i_etd_mem_port (.ref_clk_in(clk), .rst_n_in(rst_n), .bus_io(bus),
    .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack),
    .mem_err_in(1'b0));
  etd_bus_chk i_etd_bus_chk (.ref_clk_in(clk), .rst_n_in(rst_n), .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack));
  initial forever #4 clk = ~clk;
  // memory, transmit sink and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish;
    end
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && dly == 0) begin
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[9:2]];
      dly <= $urandom_range(0, 3);
    end else if (mem_req) dly <= dly - 1;
    tx_ready <= 1'($urandom_range(0, 1));
    tx_done <= tx_valid && tx_ready && tx_last && !tx_bad && !rfail && !colf;
    tx_col <= tx_valid && tx_ready && tx_last && !tx_bad && colf;
    if (tx_col) colf <= 1'b0;
    tx_rfail <= tx_valid && tx_ready && tx_last && !tx_bad && rfail;
    if (tx_valid && tx_ready) begin
      if (tx_last) begin
        ends++;
        flags = {tx_nocrc, tx_bad, tx_fault};
      end else for (int i = 0; i < tx_bytes; i++) got.push_back(tx_data[8 * i +: 8]);
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic swr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    srd(a, d);
    chk(d, e);
  endtask
  task automatic idle;
    logic [31:0] d;
    for (int n = 0; n < 300; n++) begin
      srd(st, d);
      if (d[4:3] === 2'b00) return;
    end
    chk(d, 32'h0);
  endtask
  // entry at a, buffer ba, control ctl; bytes join want
  task automatic desc(input logic [31:0] a, input logic [31:0] ba, input logic [31:0] ctl);
    logic [31:0] p;
    logic [7:0]  b;
    mem[a[9:2]] = ba;
    mem[a[9:2] + 8'h01] = ctl;
    for (int i = 0; i < ctl[10:0]; i++) begin
      p = ba + 32'(i);
      b = 8'($urandom);
      mem[p[9:2]][8 * p[1:0] +: 8] = b;
      want.push_back(b);
    end
  endtask
  task automatic cmp_stream;
    chk(32'(got.size()), 32'(want.size()));
    foreach (want[i]) if (i < got.size()) chk(32'(got[i]), 32'(want[i]));
    got.delete();
    want.delete();
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin : main
    logic [31:0] c, d;
    c = $urandom(29785);
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // crc frame hit by one collision, then a used entry
    c = 32'($urandom_range(1, 20));
    desc(32'h0, 32'h201, c);
    desc(32'h8, 32'h280, 32'h0);
    d = 32'h8000 | 32'($urandom_range(1, 8));
    desc(32'h10, 32'h302, d);
    desc(32'h18, 32'h0, 32'h8000_0000);
    while (want.size() < 60) want.push_back(8'h00);
    want = {want, want};
    swr(qp, 32'h0);
    swr(ct, 32'h208);
    swr(ct, 32'h208);
    idle;
    cmp_stream;
    chk(32'(flags), 32'h0);
    chk(mem[1], c | 32'h8000_0000);
    chk(mem[3], 32'h0);
    chk(mem[5], d);
    rchk(qp, 32'h18);
    // pause, halt, disable, pointer write
    pause <= 1'b1;
    swr(cf, 32'h2000);
    swr(ct, 32'h208);
    repeat (20) @(posedge clk);
    srd(st, d);
    chk(32'(d[3]), 32'h1);
    rchk(qp, 32'h18);
    swr(ct, 32'h408);
    rchk(st, 32'h0);
    swr(ct, 32'h208);
    swr(ct, 32'h0);
    rchk(qp, 32'h0);
    swr(ct, 32'h208);
    swr(qp, 32'h18);
    rchk(st, 32'h0);
    rchk(qp, 32'h18);
    pause <= 1'b0;
    swr(cf, 32'h0);
    // one-buffer no-crc frame with wrap
    c = 32'h4001_8003;
    desc(32'h18, 32'h2C0, c);
    swr(ct, 32'h208);
    idle;
    cmp_stream;
    chk(32'(flags), 32'h4);
    chk(mem[7], c | 32'h8000_0000);
    rchk(qp, 32'h18);
    // four empty frames roll over
    for (int i = 0; i < 4; i++) desc(32'h40 + 32'(8 * i), 32'h0, 32'h0001_8000);
    c = 32'(ends);
    swr(qp, 32'h40);
    swr(ct, 32'h208);
    idle;
    chk(32'(ends) - c, 32'h4);
    chk(mem[23], 32'h8001_8000);
    rchk(qp, 32'h40);
    // used entry in mid-frame
    desc(32'h80, 32'h340, 32'h4);
    desc(32'h88, 32'h0, 32'h8000_0000);
    swr(qp, 32'h80);
    swr(ct, 32'h208);
    idle;
    chk(32'(flags), 32'h3);
    chk(mem[33], 32'h9800_0004);
    rchk(qp, 32'h80);
    cmp_stream;
    // retry limit reached
    desc(32'hC0, 32'h380, 32'h8002);
    desc(32'hC8, 32'h0, 32'h8000_0000);
    rfail = 1'b1;
    swr(qp, 32'hC0);
    swr(ct, 32'h208);
    idle;
    rfail = 1'b0;
    chk(mem[49], 32'hA000_8002);
    rchk(qp, 32'hC0);
    tally_and_finish;
  end
endmodule // eth_tx_descriptor_dma_tb
`default_nettype wire
